/* File: verilog/bas_addr_snoop.sv */
/*
 * Backplane address snoop: latches the address, modifier, direction and
 * long-word qualifier of every backplane command into three read-only
 * status words and answers reads of them addressed to this chip.
 * Assumes backplane pins are asynchronous to clk and that address lines
 * are stable while the address strobe is low.
 */
// Overview of operation
// (RQ1) Every backplane command is captured and held until the next, readable in three words.
// (RQ2) Only the bus interface chip answers for these words; other chip selects are ignored.
// (RQ3) High word bits 4..0 carry the slot field, address lines 23..19.
// (RQ4) High word bits 12..8 carry the board's geographic position.
// (RQ5) Low word bits 14..8 carry the chip select field, address lines 18..12.
// (RQ6) Low word bits 6..0 carry the register index field, address lines 8..2.
// (RQ7) Medium word bits 13..8 carry the address modifier of the last command.
// (RQ8) Medium word bits 5..4 carry the muon field, lines 10..9, and bit 6 line 11.
// (RQ9) Medium word bit 3 is the inverted write strobe, and bit 1 is address line 1.
// (RQ10) Medium word bit 0 is the inverted long-word strobe.
// (RQ11) Unused bits read zero and writes to the three words change nothing.
`timescale 1ns/1ps
`default_nettype none

module bas_addr_snoop (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Backplane pins
    input wire bas_pkg::bas_vme_pins_t vmePins,
    input wire logic [bas_pkg::GEO_W-1:0] geographicPosition,
    // Register answer
    output logic [bas_pkg::WORD_W-1:0] rdData,
    output logic rdValid,
    output logic wrIgnored,
    output logic cmdSeen
);

    localparam int PIN_W = $bits(bas_pkg::bas_vme_pins_t);
    localparam int SYNC_W = PIN_W + bas_pkg::GEO_W;

    // Synchronised pins
    logic [SYNC_W-1:0] syncBundle;
    bas_pkg::bas_vme_pins_t pinsS;
    logic [bas_pkg::GEO_W-1:0] geoS;

    bas_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .asyncIn({vmePins, geographicPosition}),
        .syncOut(syncBundle)
    );

    assign pinsS = bas_pkg::bas_vme_pins_t'(syncBundle[SYNC_W-1 -: PIN_W]);
    assign geoS = syncBundle[bas_pkg::GEO_W-1:0];

    // State and captured command
    bas_pkg::bas_state_t state_reg;
    bas_pkg::bas_state_t state_next;
    bas_pkg::bas_snap_t snap_reg;
    bas_pkg::bas_snap_t snap_next;
    logic [bas_pkg::GEO_W-1:0] geo_reg;
    logic [bas_pkg::WORD_W-1:0] rdData_reg;
    logic [bas_pkg::WORD_W-1:0] rdData_next;
    logic rdValid_reg;
    logic rdValid_next;
    logic wrIgnored_reg;
    logic wrIgnored_next;
    logic cmdSeen_reg;
    logic cmdSeen_next;

    // Field extraction from a captured address
    function automatic logic [bas_pkg::CHIP_W-1:0] chipOf(input logic [23:1] a);
        chipOf = a[bas_pkg::CHIP_A_LSB +: bas_pkg::CHIP_W];
    endfunction

    function automatic logic [bas_pkg::REGIDX_W-1:0] regIdxOf(input logic [23:1] a);
        regIdxOf = a[bas_pkg::REGIDX_A_LSB +: bas_pkg::REGIDX_W];
    endfunction

    // Status word assembly; every bit not placed stays zero
    logic [bas_pkg::WORD_W-1:0] highWord;
    logic [bas_pkg::WORD_W-1:0] lowWord;
    logic [bas_pkg::WORD_W-1:0] medWord;

    always_comb
    begin
        highWord = bas_pkg::WORD_RESET; // see (RQ11)
        highWord[bas_pkg::HIGH_SLOT_LSB +: bas_pkg::SLOT_W] =
            snap_reg.addr[bas_pkg::SLOT_A_LSB +: bas_pkg::SLOT_W]; // see (RQ3)
        highWord[bas_pkg::HIGH_GEO_LSB +: bas_pkg::GEO_W] = geo_reg; // see (RQ4)
    end

    always_comb
    begin
        lowWord = bas_pkg::WORD_RESET; // see (RQ11)
        lowWord[bas_pkg::LOW_CHIP_LSB +: bas_pkg::CHIP_W] = chipOf(snap_reg.addr); // see (RQ5)
        lowWord[bas_pkg::LOW_REGIDX_LSB +: bas_pkg::REGIDX_W] =
            regIdxOf(snap_reg.addr); // see (RQ6)
    end

    always_comb
    begin
        medWord = bas_pkg::WORD_RESET; // see (RQ11)
        medWord[bas_pkg::MED_AM_LSB +: bas_pkg::AM_W] = snap_reg.am; // see (RQ7)
        medWord[bas_pkg::MED_A11_BIT] = snap_reg.addr[bas_pkg::A11_LINE]; // see (RQ8)
        medWord[bas_pkg::MED_MUON_LSB +: bas_pkg::MUON_W] =
            snap_reg.addr[bas_pkg::MUON_A_LSB +: bas_pkg::MUON_W]; // see (RQ8)
        // Inverted write strobe, so the bit is set for writes
        medWord[bas_pkg::MED_RD_BIT] = !snap_reg.readCycle; // see (RQ9)
        medWord[bas_pkg::MED_A1_BIT] = snap_reg.addr[bas_pkg::A1_LINE]; // see (RQ9)
        medWord[bas_pkg::MED_LWORD_BIT] = snap_reg.longWord; // see (RQ10)
    end

    // Decode of the captured command
    wire strobeLow = !pinsS.asN;
    wire chipHit = chipOf(snap_reg.addr) == bas_pkg::BUS_IF_CHIP_CODE; // see (RQ2)
    wire [bas_pkg::REGIDX_W-1:0] capIdx = regIdxOf(snap_reg.addr);
    wire hitHigh = chipHit && capIdx == bas_pkg::IDX_LAST_BUS_ADDR_HIGH;
    wire hitLow = chipHit && capIdx == bas_pkg::IDX_LAST_BUS_ADDR_LOW;
    wire hitMed = chipHit && capIdx == bas_pkg::IDX_LAST_BUS_ADDR_MEDIUM;
    wire regHit = hitHigh || hitLow || hitMed;
    wire [bas_pkg::WORD_W-1:0] selWord = hitHigh ? highWord :
                                         hitLow ? lowWord :
                                         hitMed ? medWord : bas_pkg::WORD_RESET;

    // A read of these words returns the snapshot of that very read, since
    // capture precedes decode; software sees its own access in them.
    always_comb
    begin
        state_next = state_reg;
        snap_next = snap_reg;
        rdData_next = rdData_reg;
        rdValid_next = 1'b0;
        wrIgnored_next = 1'b0;
        cmdSeen_next = 1'b0;
        case (state_reg)
            bas_pkg::ST_IDLE:
            begin
                if (strobeLow)
                begin
                    snap_next.addr = pinsS.addr; // see (RQ1)
                    snap_next.am = pinsS.am;
                    snap_next.readCycle = pinsS.writeN;
                    snap_next.longWord = !pinsS.lwordN;
                    cmdSeen_next = 1'b1;
                    state_next = bas_pkg::ST_DECODE;
                end
            end
            bas_pkg::ST_DECODE:
            begin
                if (regHit && snap_reg.readCycle)
                begin
                    rdData_next = selWord; // see (RQ1)
                    rdValid_next = 1'b1;
                end
                else if (regHit)
                begin
                    // Write data is dropped; snapshot is untouched
                    wrIgnored_next = 1'b1; // see (RQ11)
                end
                state_next = bas_pkg::ST_BUSY;
            end
            bas_pkg::ST_BUSY:
            begin
                // One capture per strobe, no matter how long it is held
                if (!strobeLow)
                begin
                    state_next = bas_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_next = bas_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            // Synchronised strobe resets low; waiting in BUSY for it to read
            // high keeps reset from faking a command or catching one half way
            state_reg <= bas_pkg::ST_BUSY;
            snap_reg <= bas_pkg::SNAP_RESET;
            geo_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            snap_reg <= snap_next;
            geo_reg <= geoS;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdData_reg <= bas_pkg::WORD_RESET;
            rdValid_reg <= 1'b0;
            wrIgnored_reg <= 1'b0;
            cmdSeen_reg <= 1'b0;
        end
        else
        begin
            rdData_reg <= rdData_next;
            rdValid_reg <= rdValid_next;
            wrIgnored_reg <= wrIgnored_next;
            cmdSeen_reg <= cmdSeen_next;
        end
    end

    assign rdData = rdData_reg;
    assign rdValid = rdValid_reg;
    assign wrIgnored = wrIgnored_reg;
    assign cmdSeen = cmdSeen_reg;

endmodule

`default_nettype wire

/* File: shared/bas_pkg.sv */
/*
 * Constants and carrier types for the backplane address snoop block:
 * field positions of the three status words, backplane address line
 * positions, register indices, reset values and the state encoding.
 * Assumes a single 100 MHz system clock domain in the user of the package.
 */
package bas_pkg;

    // Width of each status word
    localparam int WORD_W = 16;

    // Field widths
    localparam int SLOT_W = 5;
    localparam int GEO_W = 5;
    localparam int CHIP_W = 7;
    localparam int REGIDX_W = 7;
    localparam int AM_W = 6;
    localparam int MUON_W = 2;

    // Backplane address line positions of each field
    localparam int SLOT_A_LSB = 19;
    localparam int CHIP_A_LSB = 12;
    localparam int REGIDX_A_LSB = 2;
    localparam int MUON_A_LSB = 9;
    localparam int A11_LINE = 11;
    localparam int A1_LINE = 1;

    // High word layout
    localparam int HIGH_SLOT_LSB = 0;
    localparam int HIGH_GEO_LSB = 8;

    // Low word layout
    localparam int LOW_REGIDX_LSB = 0;
    localparam int LOW_CHIP_LSB = 8;

    // Medium word layout
    localparam int MED_LWORD_BIT = 0;
    localparam int MED_A1_BIT = 1;
    localparam int MED_RD_BIT = 3;
    localparam int MED_MUON_LSB = 4;
    localparam int MED_A11_BIT = 6;
    localparam int MED_AM_LSB = 8;

    // Register indices as seen in the register index field
    localparam logic [REGIDX_W-1:0] IDX_LAST_BUS_ADDR_HIGH = 7'h79;
    localparam logic [REGIDX_W-1:0] IDX_LAST_BUS_ADDR_LOW = 7'h7A;
    localparam logic [REGIDX_W-1:0] IDX_LAST_BUS_ADDR_MEDIUM = 7'h7B;

    // Chip select code of the bus interface chip (arbitrary value)
    localparam logic [CHIP_W-1:0] BUS_IF_CHIP_CODE = 7'h01;

    // Reset values
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

    // Backplane pins, active-low strobes as on the bus
    typedef struct packed {
        logic asN;
        logic writeN;
        logic lwordN;
        logic [AM_W-1:0] am;
        logic [23:1] addr;
    } bas_vme_pins_t;

    // Snapshot of the last observed command
    typedef struct packed {
        logic [23:1] addr;
        logic [AM_W-1:0] am;
        logic readCycle;
        logic longWord;
    } bas_snap_t;

    localparam bas_snap_t SNAP_RESET = '{addr: 23'h000000, am: 6'h00,
        readCycle: 1'b0, longWord: 1'b0};

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DECODE = 3'b010,
        ST_BUSY = 3'b100
    } bas_state_t;

endpackage

/* File: verilog/bas_sync.sv */
/*
 * Two-flop synchroniser for a bundle of asynchronous levels.
 * Assumes the bundle is quasi-static relative to the sampling clock;
 * multi-bit values are only trusted once their qualifying strobe settles.
 */
`timescale 1ns/1ps
`default_nettype none

module bas_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Levels
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);

    logic [W-1:0] stage1_reg;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stage1_reg <= '0;
            syncOut <= '0;
        end
        else
        begin
            stage1_reg <= asyncIn;
            syncOut <= stage1_reg;
        end
    end

endmodule

`default_nettype wire

/* File: tb/bas_addr_snoop_monitor.sv */
/* Assertions on the snoop block ports.
   Assumes the master holds pins stable while the strobe is low. */
`timescale 1ns/1ps
`default_nettype none
module bas_addr_snoop_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Backplane
    input wire bas_pkg::bas_vme_pins_t vmePins,
    input wire logic [bas_pkg::GEO_W-1:0] geographicPosition,
    // Answer
    input wire logic [bas_pkg::WORD_W-1:0] rdData,
    input wire logic rdValid,
    input wire logic wrIgnored,
    input wire logic cmdSeen
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    wire logic [6:0] idx = vmePins.addr[8:2];
    wire logic hit = vmePins.addr[18:12] == bas_pkg::BUS_IF_CHIP_CODE
        && idx inside {[7'h79:7'h7B]};
    wire logic [15:0] expHigh = {3'h0, geographicPosition, 3'h0, vmePins.addr[23:19]};
    wire logic [15:0] expLow = {1'h0, vmePins.addr[18:12], 1'h0, idx};
    wire logic [15:0] expMed = {2'h0, vmePins.am, 1'h0, vmePins.addr[11:9],
        ~vmePins.writeN, 1'h0, vmePins.addr[1], ~vmePins.lwordN};
    property p_capture;
        $fell(vmePins.asN) |-> ##[2:4] cmdSeen;
    endproperty
    a_capture: assert property (p_capture) else $error("strobe not captured");
    property p_cause;
        cmdSeen |-> !$past(vmePins.asN, 2);
    endproperty
    a_cause: assert property (p_cause) else $error("capture without strobe");
    property p_pulse;
        cmdSeen |=> !cmdSeen;
    endproperty
    a_pulse: assert property (p_pulse) else $error("capture twice");
    property p_readHit;
        cmdSeen && hit && vmePins.writeN |=> rdValid && !wrIgnored;
    endproperty
    a_readHit: assert property (p_readHit) else $error("read not answered");
    property p_writeDrop;
        cmdSeen && hit && !vmePins.writeN |=> wrIgnored && !rdValid;
    endproperty
    a_writeDrop: assert property (p_writeDrop) else $error("write not dropped");
    property p_foreign;
        cmdSeen && !hit |=> !rdValid && !wrIgnored;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign access answered");
    property p_high;
        rdValid && idx == bas_pkg::IDX_LAST_BUS_ADDR_HIGH |-> rdData == expHigh;
    endproperty
    a_high: assert property (p_high) else $error("high word wrong");
    property p_low;
        rdValid && idx == bas_pkg::IDX_LAST_BUS_ADDR_LOW |-> rdData == expLow;
    endproperty
    a_low: assert property (p_low) else $error("low word wrong");
    property p_med;
        rdValid && idx == bas_pkg::IDX_LAST_BUS_ADDR_MEDIUM |-> rdData == expMed;
    endproperty
    a_med: assert property (p_med) else $error("medium word wrong");
    property p_hold;
        !rdValid |-> $stable(rdData);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    c_read: cover property (rdValid);
    c_write: cover property (wrIgnored);
    c_foreign: cover property (cmdSeen && !hit);
endmodule
`default_nettype wire

/* File: tb/bas_vme_master.sv */
/* Behavioural backplane master issuing one command per call.
   Assumes the caller never overlaps calls. */
`timescale 1ns/1ps
`default_nettype none
module bas_vme_master (
    // Clock
    input wire logic clk,
    // Backplane
    output var bas_pkg::bas_vme_pins_t vmePins
);
    initial vmePins = '{asN: 1'b1, writeN: 1'b1, lwordN: 1'b1, am: 6'h00, addr: 23'h000000};
    task automatic cycle(input logic [23:1] a, input logic [5:0] am, input logic wrN,
        input logic lwN, input int lowCyc);
        @(posedge clk);
        vmePins.addr <= a;
        vmePins.am <= am;
        vmePins.writeN <= wrN;
        vmePins.lwordN <= lwN;
        repeat (2) @(posedge clk);
        vmePins.asN <= 1'b0;
        repeat (lowCyc) @(posedge clk);
        vmePins.asN <= 1'b1;
        // Released lines must not keep the old value
        vmePins.addr <= ~a;
        vmePins.am <= ~am;
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: tb/bas_addr_snoop_tb.sv */
/* Self-checking bench for the snoop block.
   Assumes the monitor and master model are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module bas_addr_snoop_tb;
    localparam logic [6:0] CHIP = bas_pkg::BUS_IF_CHIP_CODE;
    localparam logic [6:0] H = bas_pkg::IDX_LAST_BUS_ADDR_HIGH;
    localparam logic [6:0] L = bas_pkg::IDX_LAST_BUS_ADDR_LOW;
    localparam logic [6:0] M = bas_pkg::IDX_LAST_BUS_ADDR_MEDIUM;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] geo = 5'h15;
    bas_pkg::bas_vme_pins_t pins;
    logic [15:0] rdData;
    logic [15:0] lastRd;
    logic rdValid, wrIgnored, cmdSeen;
    int miscompares = 0, checkCount = 0, nRd = 0, nWr = 0, nCmd = 0;
    always #5 clk = ~clk;
    bas_vme_master i_master (.clk(clk), .vmePins(pins));
    bas_addr_snoop i_dut (.clk(clk), .resetn(resetn), .vmePins(pins),
        .geographicPosition(geo), .rdData(rdData), .rdValid(rdValid),
        .wrIgnored(wrIgnored), .cmdSeen(cmdSeen));
    always @(posedge clk)
    begin
        nRd += (rdValid === 1'b1);
        nWr += (wrIgnored === 1'b1);
        nCmd += (cmdSeen === 1'b1);
        if (rdValid === 1'b1)
            lastRd = rdData;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expd);
        checkCount++;
        if (seen !== expd)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, expd, seen);
        end
    endtask
    task automatic testDone();
        if (miscompares == 0 && checkCount > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One command, then pulse counts and the answered word are judged
    task automatic cmd(input logic [23:1] a, input logic [5:0] am, input logic wrN,
        input logic lwN, input int lowCyc);
        int r0, w0, c0;
        logic hit;
        logic [15:0] expd;
        r0 = nRd;
        w0 = nWr;
        c0 = nCmd;
        hit = a[18:12] === CHIP;
        expd = 16'h0000;
        case (a[8:2])
            H: expd = {3'h0, geo, 3'h0, a[23:19]};
            L: expd = {1'h0, a[18:12], 1'h0, a[8:2]};
            M: expd = {2'h0, am, 1'h0, a[11:9], ~wrN, 1'h0, a[1], ~lwN};
            default: hit = 1'b0;
        endcase
        i_master.cycle(a, am, wrN, lwN, lowCyc);
        check("cmdSeen pulses", 16'(nCmd - c0), 16'h0001);
        check("rdValid pulses", 16'(nRd - r0), {15'h0000, hit & wrN});
        check("wrIgnored pulses", 16'(nWr - w0), {15'h0000, hit & ~wrN});
        if (hit && wrN)
            check("rdData", lastRd, expd);
    endtask
    task automatic scenWords();
        cmd({5'h0A, CHIP, 3'h5, H, 1'h1}, 6'h3D, 1'b1, 1'b0, 6);
        cmd({5'h15, CHIP, 3'h2, L, 1'h0}, 6'h09, 1'b1, 1'b1, 12);
        cmd({5'h01, CHIP, 3'h6, M, 1'h1}, 6'h2A, 1'b1, 1'b0, 6);
        cmd({5'h1E, CHIP, 3'h1, M, 1'h0}, 6'h15, 1'b1, 1'b1, 8);
    endtask
    task automatic scenWrites();
        cmd({5'h1F, CHIP, 3'h7, H, 1'h1}, 6'h0D, 1'b0, 1'b0, 6);
        cmd({5'h00, CHIP, 3'h0, L, 1'h0}, 6'h39, 1'b0, 1'b1, 6);
        cmd({5'h11, CHIP, 3'h3, M, 1'h1}, 6'h3F, 1'b0, 1'b0, 6);
        cmd({5'h12, CHIP, 3'h4, M, 1'h0}, 6'h00, 1'b1, 1'b0, 6);
    endtask
    task automatic scenForeign();
        cmd({5'h03, 7'h02, 3'h0, H, 1'h0}, 6'h3D, 1'b1, 1'b0, 6);
        cmd({5'h04, CHIP, 3'h0, 7'h7C, 1'h0}, 6'h3D, 1'b1, 1'b0, 6);
        cmd({5'h05, CHIP, 3'h0, 7'h78, 1'h0}, 6'h3D, 1'b0, 1'b0, 6);
    endtask
    task automatic scenGeoReset();
        geo <= 5'h0A;
        repeat (5) @(posedge clk);
        cmd({5'h13, CHIP, 3'h0, H, 1'h0}, 6'h3D, 1'b1, 1'b0, 6);
        resetn <= 1'b0;
        repeat (5) @(posedge clk);
        check("rdData after reset", rdData, 16'h0000);
        resetn <= 1'b1;
        cmd({5'h07, CHIP, 3'h0, H, 1'h1}, 6'h3D, 1'b1, 1'b0, 6);
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        scenWords();
        scenWrites();
        scenForeign();
        scenGeoReset();
        testDone();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        testDone();
    end
endmodule
bind bas_addr_snoop bas_addr_snoop_monitor i_mon (.clk(clk), .resetn(resetn),
    .vmePins(vmePins), .geographicPosition(geographicPosition), .rdData(rdData),
    .rdValid(rdValid), .wrIgnored(wrIgnored), .cmdSeen(cmdSeen));
`default_nettype wire
